/* File: inc/ssdr_pkg.sv */
`default_nettype none
package ssdr_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_PART_CODE    = 8'h92;
  localparam logic [7:0] ADDR_MAIN_FLAGS   = 8'h93;
  localparam logic [7:0] ADDR_CLEAR_LOW    = 8'h94;
  localparam logic [7:0] ADDR_CLEAR_HIGH   = 8'h95;
  localparam logic [7:0] ADDR_RED_LOW      = 8'h96;
  localparam logic [7:0] ADDR_RED_HIGH     = 8'h97;
  localparam logic [7:0] ADDR_GREEN_LOW    = 8'h98;
  localparam logic [7:0] ADDR_GREEN_HIGH   = 8'h99;
  localparam logic [7:0] ADDR_BLUE_LOW     = 8'h9A;
  localparam logic [7:0] ADDR_BLUE_HIGH    = 8'h9B;
  localparam logic [7:0] ADDR_PROX_LOW     = 8'h9C;
  localparam logic [7:0] ADDR_PROX_HIGH    = 8'h9D;
  localparam logic [7:0] ADDR_SECONDARY    = 8'h9E;

  // Identification code; the value is arbitrary
  localparam logic [5:0] PART_CODE_VALUE   = 6'h15;
  localparam logic [1:0] PART_CODE_RSVD    = 2'h0;

  // Main flag bit positions
  localparam int MF_LIGHT_SAT   = 7;
  localparam int MF_PROX_SAT    = 6;
  localparam int MF_PROX_IRQ    = 5;
  localparam int MF_AMB_IRQ     = 4;
  localparam int MF_PATTERN     = 3;
  localparam int MF_MOTION      = 2;
  localparam int MF_CALIB       = 1;

  // Secondary flag bit positions
  localparam int SF_PROX_VALID  = 7;
  localparam int SF_AMB_VALID   = 6;
  localparam int SF_AMB_CNT_SAT = 4;
  localparam int SF_AMB_ANA_SAT = 3;
  localparam int SF_PROX_CONV   = 2;
  localparam int SF_PROX_REFL   = 1;
  localparam int SF_PROX_AMB    = 0;

  // Reset values
  localparam logic [7:0] MAIN_FLAGS_RESET = 8'h00;
  localparam logic [7:0] SEC_FLAGS_RESET  = 8'h00;
  localparam logic [6:0] PULSES_RESET     = 7'h01;
  localparam logic [7:0] UNMAPPED_DATA    = 8'h00;

  // Automatic pulse control marks on the averaged 10-bit converter value
  localparam logic [9:0] APC_HIGH_MARK    = 10'h300;
  localparam logic [9:0] APC_LOW_MARK     = 10'h100;
  localparam logic [6:0] PULSES_MIN       = 7'h01;

  // Divider shape: numerator is diode sum times 16, divisor diodes*pulses
  localparam int DIV_NUM_W = 16;
  localparam int DIV_DEN_W = 9;

  typedef struct packed {
    logic [15:0] clear;
    logic [15:0] red;
    logic [15:0] green;
    logic [15:0] blue;
  } ssdr_color_t;

  typedef struct packed {
    logic       ambient_saturation_irq_enable;
    logic       proximity_saturation_irq_enable;
    logic       proximity_irq_enable;
    logic       ambient_irq_enable;
    logic       pattern_irq_enable;
    logic       motion_irq_enable;
    logic [2:0] calib_cause_enable;
    logic       proximity_enable;
    logic       ambient_enable;
    logic [5:0] max_pulses;
    logic [3:0] diode_mask;
  } ssdr_cfg_t;

  typedef struct packed {
    logic converter;
    logic reflected;
    logic ambient;
  } ssdr_prox_sat_t;

  typedef enum logic [1:0] {
    PX_IDLE = 2'b00,
    PX_LOAD = 2'b01,
    PX_WAIT = 2'b11
  } ssdr_px_state_t;

endpackage
`default_nettype wire

/* File: rtl/ssdr_div.sv */
`default_nettype none
module ssdr_div
  import ssdr_pkg::*;
#(
  parameter int NW = 16,
  parameter int DW = 9
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  // Request
  input  wire logic          start,
  input  wire logic [NW-1:0] num,
  input  wire logic [DW-1:0] den,
  // Answer
  output logic               busy,
  output logic               done,
  output logic [NW-1:0]      quot
);

  logic [DW:0]   rem_r;
  logic [NW-1:0] q_r;
  logic [DW-1:0] den_r;
  logic [5:0]    cnt_r;
  logic [DW:0]   trial;

  assign trial = {rem_r[DW-1:0], q_r[NW-1]};
  assign quot  = q_r;
  assign busy  = (cnt_r != 6'h00);

  // One quotient bit per cycle; divisor must be nonzero
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rem_r <= '0;
      q_r   <= '0;
      den_r <= '0;
      cnt_r <= 6'h00;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        rem_r <= '0;
        q_r   <= num;
        den_r <= den;
        cnt_r <= 6'(NW);
      end else if (busy) begin
        if (trial >= {1'b0, den_r}) begin
          rem_r <= trial - {1'b0, den_r};
          q_r   <= {q_r[NW-2:0], 1'b1};
        end else begin
          rem_r <= trial;
          q_r   <= {q_r[NW-2:0], 1'b0};
        end
        cnt_r <= cnt_r - 6'h01;
        done  <= (cnt_r == 6'h01);
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/ssdr_regs.sv */
// Overview of operation
// - Main flags change only by hardware events
// - Bit 7 reports ambient saturation when enabled
// - Bit 6 reports proximity analog saturation
// - Bit 5 reports qualified proximity events
// - Bit 4 reports qualified ambient events
// - Bit 3 pattern done, mirrored outward
// - Bit 2 motion FIFO level or valid
// - Motion flag clears when FIFO drained
// - Bit 1 calibration or enabled cause events
// - Clear low read latches all colors
// - Colors little-endian in C,R,G,B order
// - Proximity result 14 bits over two bytes
// - Pulse count falls as signal grows
// - Result is converter times 16 over pulses
// - Average over unmasked diodes only
// - Proximity valid after cycle, cleared otherwise
// - Ambient valid after cycle, cleared otherwise
// - Ambient counter saturation flag bit 4
// - Ambient analog saturation flag bit 3
// - Proximity saturation detail bits 2..0
// - Fixed identification code, low bits zero
// - Bit 7 ambient saturation only while enabled
// - Mask bit removes diode from average
`default_nettype none
module ssdr_regs
  import ssdr_pkg::*;
(
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rstn,
  // Register read port
  input  wire logic            rd_en,
  input  wire logic [7:0]      rd_addr,
  output logic      [7:0]      rd_data_r,
  output logic                 rd_valid_r,
  // Configuration from the control registers
  input  wire ssdr_cfg_t       cfg,
  // Ambient engine
  input  wire logic            amb_cycle_done,
  input  wire ssdr_color_t     color_live,
  input  wire logic            amb_counter_sat,
  input  wire logic            amb_analog_sat,
  input  wire logic            amb_irq_event,
  // Proximity engine
  input  wire logic            prox_cycle_done,
  input  wire logic [3:0][9:0] diode_adc,
  input  wire ssdr_prox_sat_t  prox_sat,
  input  wire logic            prox_irq_event,
  output logic      [6:0]      pulses_used_r,
  // Pattern, motion and calibration engines
  input  wire logic            pattern_done,
  input  wire logic [5:0]      motion_fifo_level,
  input  wire logic [5:0]      motion_fifo_threshold,
  input  wire logic            motion_data_valid,
  input  wire logic            motion_engine_mode,
  input  wire logic            fifo_drained,
  input  wire logic            calib_done,
  input  wire logic [2:0]      calib_cause,
  input  wire logic [7:0]      main_flags_clear,
  // Flag outputs
  output logic      [7:0]      main_flags_r,
  output logic                 pattern_engine_flag
);

  ssdr_color_t    color_latch_r;
  logic [7:0]     sec_flags_r;
  logic [13:0]    prox_result_r;
  ssdr_prox_sat_t prox_sat_cap_r;
  ssdr_px_state_t px_state_r;
  logic [15:0]    div_num_r;
  logic [8:0]     div_den_r;
  logic           apc_down_r;
  logic           apc_up_r;
  logic           zero_diodes_r;
  logic           mode_d_r;
  logic           prox_en_d_r;
  logic           amb_en_d_r;
  logic [7:0]     rd_data_nxt;
  logic [7:0]     flag_set;
  logic [7:0]     flag_clr;
  logic [11:0]    diode_sum;
  logic [2:0]     diode_cnt;
  logic [6:0]     pulses_max;
  logic           div_busy;
  logic           div_done;
  logic [15:0]    div_quot;
  logic           px_accept;
  logic           rd_clear_low;
  logic           rd_prox_high;
  logic           prox_update;

  assign pulses_max   = {1'b0, cfg.max_pulses} + 7'h01;
  assign rd_clear_low = rd_en && (rd_addr == ADDR_CLEAR_LOW);
  assign rd_prox_high = rd_en && (rd_addr == ADDR_PROX_HIGH);
  assign px_accept    = prox_cycle_done && (px_state_r == PX_IDLE);

  always_comb begin
    diode_sum = 12'h000;
    diode_cnt = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (!cfg.diode_mask[i]) begin
        diode_sum = diode_sum + {2'h0, diode_adc[i]};
        diode_cnt = diode_cnt + 3'h1;
      end
    end
  end

  // Samples arriving while a division runs are dropped
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      px_state_r     <= PX_IDLE;
      div_num_r      <= 16'h0000;
      div_den_r      <= 9'h000;
      apc_down_r     <= 1'b0;
      apc_up_r       <= 1'b0;
      zero_diodes_r  <= 1'b0;
      prox_sat_cap_r <= '0;
    end else begin
      unique case (px_state_r)
        PX_IDLE: begin
          if (prox_cycle_done) begin
            div_num_r      <= {diode_sum, 4'h0};
            // Operands widened first so the product cannot wrap
            div_den_r      <= {6'h00, diode_cnt} * {2'h0, pulses_used_r};
            apc_down_r     <= {1'h0, diode_sum} >=
                              ({10'h000, diode_cnt} * {3'h0, APC_HIGH_MARK});
            apc_up_r       <= {1'h0, diode_sum} <
                              ({10'h000, diode_cnt} * {3'h0, APC_LOW_MARK});
            zero_diodes_r  <= (diode_cnt == 3'h0);
            prox_sat_cap_r <= prox_sat;
            px_state_r     <= PX_LOAD;
          end
        end
        PX_LOAD: begin
          px_state_r <= zero_diodes_r ? PX_IDLE : PX_WAIT;
        end
        PX_WAIT: begin
          if (div_done) begin
            px_state_r <= PX_IDLE;
          end
        end
      endcase
    end
  end

  ssdr_div #(
    .NW (DIV_NUM_W),
    .DW (DIV_DEN_W)
  ) u_div (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .start   (px_state_r == PX_LOAD && !zero_diodes_r),
    .num     (div_num_r),
    .den     (div_den_r),
    .busy    (div_busy),
    .done    (div_done),
    .quot    (div_quot)
  );

  // All diodes masked gives a zero result without dividing
  assign prox_update = (px_state_r == PX_WAIT && div_done) ||
                       (px_state_r == PX_LOAD && zero_diodes_r);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prox_result_r <= 14'h0000;
    end else if (prox_update) begin
      prox_result_r <= zero_diodes_r ? 14'h0000 : div_quot[13:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pulses_used_r <= PULSES_RESET;
    end else if (pulses_used_r > pulses_max) begin
      pulses_used_r <= pulses_max;
    end else if (prox_update && apc_down_r &&
                 pulses_used_r > PULSES_MIN) begin
      pulses_used_r <= pulses_used_r - 7'h01;
    end else if (prox_update && apc_up_r &&
                 pulses_used_r < pulses_max) begin
      pulses_used_r <= pulses_used_r + 7'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mode_d_r    <= 1'b0;
      prox_en_d_r <= 1'b0;
      amb_en_d_r  <= 1'b0;
    end else begin
      mode_d_r    <= motion_engine_mode;
      prox_en_d_r <= cfg.proximity_enable;
      amb_en_d_r  <= cfg.ambient_enable;
    end
  end

  // Hardware event sources for the main flags
  always_comb begin
    flag_set = 8'h00;
    flag_set[MF_LIGHT_SAT] = amb_cycle_done &&
                             cfg.ambient_saturation_irq_enable &&
                             (amb_counter_sat || amb_analog_sat);
    // analog saturation of the sampled cycle
    flag_set[MF_PROX_SAT]  = px_accept &&
                             cfg.proximity_saturation_irq_enable &&
                             (prox_sat.reflected || prox_sat.ambient);
    flag_set[MF_PROX_IRQ]  = prox_irq_event && cfg.proximity_irq_enable;
    flag_set[MF_AMB_IRQ]   = amb_irq_event && cfg.ambient_irq_enable;
    flag_set[MF_PATTERN]   = pattern_done && cfg.pattern_irq_enable;
    // FIFO level or valid at mode exit
    flag_set[MF_MOTION]    = cfg.motion_irq_enable &&
        ((motion_fifo_level != 6'h00 &&
          motion_fifo_level > motion_fifo_threshold) ||
         (motion_data_valid && mode_d_r && !motion_engine_mode));
    flag_set[MF_CALIB]     = calib_done ||
                             |(calib_cause & cfg.calib_cause_enable);
  end

  always_comb begin
    flag_clr = main_flags_clear;
    flag_clr[MF_MOTION] = main_flags_clear[MF_MOTION] || fifo_drained;
  end

  // no write path; set wins over clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      main_flags_r <= MAIN_FLAGS_RESET;
    end else begin
      main_flags_r <= ((main_flags_r & ~flag_clr) | flag_set) & 8'hFE;
    end
  end

  assign pattern_engine_flag = main_flags_r[MF_PATTERN];

  // Secondary flags: valid bits set-wins, saturation bits per cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sec_flags_r <= SEC_FLAGS_RESET;
    end else begin
      if (prox_update) begin
        sec_flags_r[SF_PROX_VALID] <= 1'b1;
      end else if (rd_prox_high ||
                   (cfg.proximity_enable && !prox_en_d_r)) begin
        sec_flags_r[SF_PROX_VALID] <= 1'b0;
      end
      if (amb_cycle_done) begin
        sec_flags_r[SF_AMB_VALID] <= 1'b1;
      end else if (rd_clear_low ||
                   (cfg.ambient_enable && !amb_en_d_r)) begin
        sec_flags_r[SF_AMB_VALID] <= 1'b0;
      end
      if (amb_cycle_done) begin
        sec_flags_r[SF_AMB_CNT_SAT] <= amb_counter_sat;
        sec_flags_r[SF_AMB_ANA_SAT] <= amb_analog_sat;
      end
      if (prox_update) begin
        sec_flags_r[SF_PROX_CONV] <= prox_sat_cap_r.converter;
        sec_flags_r[SF_PROX_REFL] <= prox_sat_cap_r.reflected;
        sec_flags_r[SF_PROX_AMB]  <= prox_sat_cap_r.ambient;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      color_latch_r <= '0;
    end else if (rd_clear_low) begin
      color_latch_r <= color_live;
    end
  end

  always_comb begin
    unique case (rd_addr)
      ADDR_PART_CODE:  rd_data_nxt = {PART_CODE_VALUE, PART_CODE_RSVD};
      ADDR_MAIN_FLAGS: rd_data_nxt = main_flags_r;
      ADDR_CLEAR_LOW:  rd_data_nxt = color_live.clear[7:0];
      ADDR_CLEAR_HIGH: rd_data_nxt = color_latch_r.clear[15:8];
      ADDR_RED_LOW:    rd_data_nxt = color_latch_r.red[7:0];
      ADDR_RED_HIGH:   rd_data_nxt = color_latch_r.red[15:8];
      ADDR_GREEN_LOW:  rd_data_nxt = color_latch_r.green[7:0];
      ADDR_GREEN_HIGH: rd_data_nxt = color_latch_r.green[15:8];
      ADDR_BLUE_LOW:   rd_data_nxt = color_latch_r.blue[7:0];
      ADDR_BLUE_HIGH:  rd_data_nxt = color_latch_r.blue[15:8];
      ADDR_PROX_LOW:   rd_data_nxt = prox_result_r[7:0];
      ADDR_PROX_HIGH:  rd_data_nxt = {2'h0, prox_result_r[13:8]};
      ADDR_SECONDARY:  rd_data_nxt = sec_flags_r & 8'hDF;
      default:         rd_data_nxt = UNMAPPED_DATA;
    endcase
  end

  // one byte per strobe, next cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_en;
      if (rd_en) begin
        rd_data_r <= rd_data_nxt;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  part_code_read_a: assert property (
    rd_en && rd_addr == ADDR_PART_CODE |=>
      rd_valid_r && rd_data_r == {PART_CODE_VALUE, 2'h0})
    else $error("part code read wrong");

  color_snapshot_a: assert property (
    rd_clear_low |=> color_latch_r == $past(color_live))
    else $error("color snapshot not taken");

  red_high_map_a: assert property (
    rd_en && rd_addr == ADDR_RED_HIGH && !rd_clear_low |=>
      rd_data_r == $past(color_latch_r.red[15:8]))
    else $error("red high byte mismatch");

  prox_high_zero_a: assert property (
    rd_prox_high |=> rd_data_r[7:6] == 2'h0)
    else $error("proximity high byte upper bits set");

  light_sat_gate_a: assert property (
    !main_flags_r[MF_LIGHT_SAT] && !cfg.ambient_saturation_irq_enable
      |=> !main_flags_r[MF_LIGHT_SAT])
    else $error("ambient saturation flag without enable");

  motion_drain_a: assert property (
    fifo_drained && !flag_set[MF_MOTION] |=> !main_flags_r[MF_MOTION])
    else $error("motion flag survived drain");

  flags_cause_a: assert property (
    $changed(main_flags_r) |->
      $past(flag_set) != 8'h00 || $past(flag_clr) != 8'h00)
    else $error("main flags changed without cause");

  prox_valid_set_a: assert property (
    prox_update |=> sec_flags_r[SF_PROX_VALID] &&
      prox_result_r == (zero_diodes_r ? 14'h0000 : $past(div_quot[13:0])))
    else $error("proximity completion not reported");

  amb_valid_clr_a: assert property (
    rd_clear_low && !amb_cycle_done |=> !sec_flags_r[SF_AMB_VALID])
    else $error("ambient valid not cleared by read");

  pulse_range_a: assert property (
    pulses_used_r >= PULSES_MIN && pulses_used_r <= 7'h40)
    else $error("pulse count out of range");

  prox_done_bound_a: assert property (
    px_state_r == PX_LOAD && !zero_diodes_r |-> ##[17:19] prox_update)
    else $error("proximity division overran");

  color_pair_c: cover property (
    rd_clear_low ##1 rd_en && rd_addr == ADDR_CLEAR_HIGH);
  prox_done_c: cover property (prox_update && apc_down_r);
  motion_set_c: cover property (
    $rose(main_flags_r[MF_MOTION]) ##[1:20] fifo_drained);

endmodule
`default_nettype wire

/* File: bench/ssdr_host.sv */
`default_nettype none
module ssdr_host (
  // Clock
  input  wire logic       sys_clk,
  // Register read port
  output var  logic       rd_en,
  output var  logic [7:0] rd_addr,
  input  wire logic [7:0] rd_data_r,
  input  wire logic       rd_valid_r
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    rd_en   = 1'b0;
    rd_addr = 8'hFF;
  end

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    @(posedge sys_clk);
    #2;
    rd_en   = 1'b1;
    rd_addr = a;
    @(posedge sys_clk);
    #2;
    rd_en   = 1'b0;
    // Address is meaningless between reads, so scramble it
    rd_addr = ~a;
    ok      = (rd_valid_r === 1'b1);
    d       = rd_data_r;
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ssdr_pkg::*;

  logic            sys_clk = 1'b0;
  logic            rstn = 1'b0;
  logic            rd_en;
  logic [7:0]      rd_addr;
  logic [7:0]      rd_data_r;
  logic            rd_valid_r;
  ssdr_cfg_t       cfg;
  ssdr_color_t     color_live;
  logic            amb_counter_sat;
  logic            amb_analog_sat;
  logic [3:0][9:0] diode_adc;
  ssdr_prox_sat_t  prox_sat;
  logic [6:0]      pulses_used_r;
  logic [5:0]      motion_fifo_level;
  logic [5:0]      motion_fifo_threshold;
  logic            motion_data_valid;
  logic            motion_engine_mode;
  logic [7:0]      main_flags_clear;
  logic [7:0]      main_flags_r;
  logic            pattern_engine_flag;
  logic [9:0]      ev;
  logic [7:0]      fx;
  logic [15:0]     rows [17];
  int              evs [7] = '{3, 1, 4, 5, 7, 8, 9};
  int              bits [7] = '{5, 4, 3, 1, 1, 1, 1};
  int              errors = 0;
  int              n_compared = 0;

  always #12.5 sys_clk = ~sys_clk;

  ssdr_regs ssdr_regs_i (
    .sys_clk, .rstn, .rd_en, .rd_addr, .rd_data_r, .rd_valid_r, .cfg,
    .amb_cycle_done(ev[0]), .color_live, .amb_counter_sat,
    .amb_analog_sat, .amb_irq_event(ev[1]), .prox_cycle_done(ev[2]),
    .diode_adc, .prox_sat, .prox_irq_event(ev[3]), .pulses_used_r,
    .pattern_done(ev[4]), .motion_fifo_level, .motion_fifo_threshold,
    .motion_data_valid, .motion_engine_mode, .fifo_drained(ev[6]),
    .calib_done(ev[5]), .calib_cause(ev[9:7]), .main_flags_clear,
    .main_flags_r, .pattern_engine_flag
  );

  ssdr_host ssdr_host_i (
    .sys_clk, .rd_en, .rd_addr, .rd_data_r, .rd_valid_r
  );

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic pulse(input int b);
    tk(1);
    ev[b] = 1'b1;
    tk(1);
    ev = '0;
  endtask

  task automatic clr(input logic [7:0] m);
    tk(1);
    main_flags_clear = m;
    tk(1);
    main_flags_clear = '0;
  endtask

  task automatic rdc(input logic [7:0] a, e);
    logic [7:0] d;
    logic       ok;
    ssdr_host_i.rd(a, d, ok);
    chk("read valid", 16'h0001, {15'h0000, ok});
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d});
  endtask

  task automatic prox(input logic [9:0] v, d3, input logic [3:0] m,
                      input logic [13:0] r, input logic [6:0] p);
    diode_adc = {d3, v, v, v};
    cfg.diode_mask = m;
    pulse(2);
    // Result lands a fixed 18 cycles after the sample
    tk(22);
    rdc(ADDR_PROX_LOW, r[7:0]);
    rdc(ADDR_PROX_HIGH, {2'b00, r[13:8]});
    chk("pulses", 16'(p), 16'(pulses_used_r));
  endtask

  task automatic done(input string nm);
    $display("end of test %s", nm);
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    ev = '0;
    main_flags_clear = '0;
    cfg = '0;
    cfg.max_pulses = 6'h03;
    cfg.proximity_enable = 1'b1;
    cfg.ambient_enable = 1'b1;
    color_live = {16'hA1B2, 16'hC3D4, 16'hE5F6, 16'h1728};
    amb_counter_sat = 1'b0;
    amb_analog_sat = 1'b0;
    diode_adc = '0;
    prox_sat = '0;
    motion_fifo_level = '0;
    motion_fifo_threshold = 6'h04;
    motion_data_valid = 1'b0;
    motion_engine_mode = 1'b0;
    rows = '{{ADDR_PART_CODE, PART_CODE_VALUE, PART_CODE_RSVD},
      16'h9300, 16'h9500, 16'h9B00, 16'h9C00, 16'h9D00, 16'h9E00,
      16'h9100, 16'hFF00, 16'h94B2, 16'h95A1, 16'h96D4, 16'h97C3,
      16'h98F6, 16'h99E5, 16'h9A28, 16'h9B17};
    tk(2);
    rstn = 1'b1;
    // Live colours change right after the latching read
    for (int i = 0; i < 17; i++) begin
      rdc(rows[i][15:8], rows[i][7:0]);
      if (rows[i][15:8] == ADDR_CLEAR_LOW) begin
        color_live = '1;
      end
    end
    done("table");

    amb_analog_sat = 1'b1;
    pulse(0);
    rdc(ADDR_SECONDARY, 8'h48);
    rdc(ADDR_MAIN_FLAGS, 8'h00);
    cfg.ambient_saturation_irq_enable = 1'b1;
    amb_analog_sat = 1'b0;
    amb_counter_sat = 1'b1;
    pulse(0);
    amb_counter_sat = 1'b0;
    rdc(ADDR_SECONDARY, 8'h50);
    rdc(ADDR_MAIN_FLAGS, 8'h80);
    rdc(ADDR_CLEAR_LOW, 8'hFF);
    rdc(ADDR_SECONDARY, 8'h10);
    clr(8'h80);
    done("ambient");

    for (int en = 0; en < 2; en++) begin
      cfg.proximity_irq_enable = en[0];
      cfg.ambient_irq_enable = en[0];
      cfg.pattern_irq_enable = en[0];
      cfg.calib_cause_enable = {3{en[0]}};
      foreach (evs[k]) begin
        pulse(evs[k]);
        fx = (en[0] || evs[k] == 5) ? 8'(1 << bits[k]) : 8'h00;
        rdc(ADDR_MAIN_FLAGS, fx);
        chk("flags port", 16'(fx), 16'(main_flags_r));
        chk("mirror", 16'(fx[3]), 16'(pattern_engine_flag));
        clr(8'hFE);
      end
    end
    done("events");

    cfg.motion_irq_enable = 1'b1;
    motion_fifo_level = 6'h04;
    tk(2);
    rdc(ADDR_MAIN_FLAGS, 8'h00);
    motion_fifo_level = 6'h05;
    tk(2);
    rdc(ADDR_MAIN_FLAGS, 8'h04);
    motion_fifo_level = 6'h00;
    pulse(6);
    rdc(ADDR_MAIN_FLAGS, 8'h00);
    motion_engine_mode = 1'b1;
    motion_data_valid = 1'b1;
    tk(2);
    motion_engine_mode = 1'b0;
    tk(2);
    rdc(ADDR_MAIN_FLAGS, 8'h04);
    motion_data_valid = 1'b0;
    pulse(6);
    rdc(ADDR_MAIN_FLAGS, 8'h00);
    done("motion");

    prox(10'h3FF, 10'h3FF, 4'h0, 14'h3FF0, 7'h01);
    prox(10'h080, 10'h080, 4'h0, 14'h0800, 7'h02);
    prox(10'h080, 10'h080, 4'h0, 14'h0400, 7'h03);
    prox(10'h080, 10'h080, 4'h0, 14'h02AA, 7'h04);
    prox(10'h080, 10'h080, 4'h0, 14'h0200, 7'h04);
    prox(10'h300, 10'h300, 4'h0, 14'h0C00, 7'h03);
    prox(10'h200, 10'h3FF, 4'h8, 14'h0AAA, 7'h03);
    done("proximity");

    cfg.proximity_saturation_irq_enable = 1'b1;
    for (int k = 0; k < 3; k++) begin
      prox_sat = 3'(1 << k);
      pulse(2);
      tk(22);
      fx = 8'h90 | 8'(1 << k);
      rdc(ADDR_SECONDARY, fx);
      rdc(ADDR_MAIN_FLAGS, (k < 2) ? 8'h40 : 8'h00);
      rdc(ADDR_PROX_HIGH, 8'h0A);
      rdc(ADDR_SECONDARY, fx & 8'h7F);
      clr(8'h40);
    end
    done("saturation");

    tk(1);
    rstn = 1'b0;
    tk(2);
    rstn = 1'b1;
    chk("pulses", 16'(PULSES_RESET), 16'(pulses_used_r));
    rdc(ADDR_SECONDARY, SEC_FLAGS_RESET);
    rdc(ADDR_CLEAR_HIGH, 8'h00);
    rdc(ADDR_PROX_LOW, 8'h00);
    done("reset");
    close_out();
  end
endmodule
`default_nettype wire
